//--- dv/bus_arb_properties.sv
`default_nettype none
module bus_arb_properties #(
  parameter logic [2:0] FREQ_CODE = 3'h0
) (
  input wire logic       mclk,                     // clock
  input wire logic       nrst,                     // reset
  input wire logic       priority_owner_request_n, // priority pin
  input wire logic [1:0] agent_request_lines_n,    // id lines
  input wire logic       reqValid,                 // core request
  input wire logic       reqLocked,                // locked request
  input wire logic       lockActive,               // lock held
  input wire logic       own_request_line_n,       // line zero
  input wire logic       own_request_oe,           // line enable
  input wire logic       reqGrant,                 // issued
  input wire logic       reqBlocked,               // withheld
  input wire logic [1:0] agentId,                  // identity
  input wire logic       idValid,                  // identity caught
  input wire logic [2:0] bus_freq_select           // freq code
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // priority seen long enough stops new grants
  a_no_new_grant: assert property (!priority_owner_request_n[*6] ##0 !$past(lockActive)
    |-> !reqGrant) else $error("grant under priority");
  a_lock_passes: assert property (lockActive && reqLocked |=> !reqBlocked)
    else $error("locked request blocked");
  a_block_each: assert property (!priority_owner_request_n[*6] ##0 (reqValid && idValid
    && own_request_line_n && !lockActive) |=> reqBlocked) else $error("not blocked");
  a_id_capture: assert property ($rose(idValid) |-> agentId == (!$past(agent_request_lines_n[0])
    ? 2'h0 : !$past(agent_request_lines_n[1]) ? 2'h1 : 2'h3)) else $error("bad id");
  a_id_holds: assert property (idValid |=> idValid && $stable(agentId))
    else $error("id moved");
  a_line_grant: assert property ($fell(own_request_line_n) |-> reqGrant && own_request_oe)
    else $error("line without grant");
  a_freq_code: assert property (idValid |-> bus_freq_select == FREQ_CODE)
    else $error("bad freq code");
endmodule
`default_nettype wire

//--- dv/prio_agent_model.sv
`default_nettype none
module prio_agent_model (
  input  wire logic       mclk,                    // clock
  input  wire logic       nrst,                    // reset
  input  wire logic       go,                      // take ownership
  input  wire logic [3:0] nReq,                    // own requests
  output logic            priority_owner_request_n // priority pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] pending;
  // one own request completes per cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) pending <= 4'h0;
    else if (go) pending <= nReq;
    else if (pending != 4'h0) pending <= pending - 4'h1;
  end
  assign priority_owner_request_n = (pending == 4'h0);
endmodule
`default_nettype wire

//--- dv/tb_shared_bus_priority_arbitration.sv
`default_nettype none
module tb_shared_bus_priority_arbitration;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, nrst = 0, go = 0, reqValid = 0, reqLocked = 0, lockActive = 0, reqDone = 0;
  logic prio, lineN, oe, grant, blocked, idValid, got;
  logic [1:0] lines = 2'h3, agentId;
  logic [2:0] freq;
  int n_mismatch = 0, n_tests = 0;
  always #12.5 mclk = ~mclk;
  prio_agent_model i_prio_agent_model (.mclk, .nrst, .go, .nReq(4'hc),
    .priority_owner_request_n(prio));
  shared_bus_priority_arbitration #(.FREQ_CODE(3'h5)) i_shared_bus_priority_arbitration (
    .mclk, .nrst, .priority_owner_request_n(prio), .agent_request_lines_n(lines), .reqValid,
    .reqLocked, .lockActive, .reqDone, .own_request_line_n(lineN), .own_request_oe(oe),
    .reqGrant(grant), .reqBlocked(blocked), .agentId, .idValid, .bus_freq_select(freq));
  task chk(input logic c, input string m);
    n_tests++;
    if (c !== 1'b1) begin
      n_mismatch++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  task rst(input logic [1:0] l);
    @(negedge mclk) nrst = 0;
    lines = l;
    repeat (2) @(negedge mclk);
    nrst = 1;
    @(negedge mclk) lines = ~l;
    chk(idValid === 1 && agentId === (!l[0] ? 2'h0 : !l[1] ? 2'h1 : 2'h3), "id");
    chk(freq === 3'h5, "freq");
  endtask
  task waitG(input int n);
    got = 0;
    for (int i = 0; i < n && !got; i++) @(negedge mclk) got = (grant === 1);
  endtask
  task fin;
    reqValid = 0;
    lockActive = 0;
    reqLocked = 0;
    @(negedge mclk) reqDone = 1;
    @(negedge mclk) reqDone = 0;
    @(negedge mclk) chk(lineN === 1, "line release");
  endtask
  task own(input logic l);
    @(negedge mclk) go = 1;
    @(negedge mclk) go = 0;
    repeat (6) @(negedge mclk);
    lockActive = l;
    reqLocked = l;
    reqValid = 1;
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    for (int k = 0; k < 4; k++) rst(k[1:0]);
    @(negedge mclk) reqValid = 1;
    waitG(20);
    chk(got && lineN === 0 && oe === 1, "own grant");
    fin;
    own(0);
    repeat (3) @(negedge mclk) chk(blocked === 1 && grant === 0, "not held");
    waitG(20);
    chk(got, "no grant after release");
    fin;
    own(1);
    waitG(3);
    chk(got && blocked === 0, "locked held");
    fin;
    final_report;
  end
  initial begin
    #20000;
    n_mismatch++;
    final_report;
  end
endmodule
bind shared_bus_priority_arbitration bus_arb_properties #(.FREQ_CODE(FREQ_CODE)) i_props (
  .mclk, .nrst, .priority_owner_request_n, .agent_request_lines_n, .reqValid, .reqLocked,
  .lockActive, .own_request_line_n, .own_request_oe, .reqGrant, .reqBlocked, .agentId,
  .idValid, .bus_freq_select);
`default_nettype wire

//--- rtl/bus_arb_pkg.sv
`default_nettype none
package bus_arb_pkg;
  // agent identity width and codes derived from request lines seen at reset release
  localparam int unsigned ID_W        = 2;
  localparam logic [1:0]  ID_LINE0    = 2'h0;
  localparam logic [1:0]  ID_LINE1    = 2'h1;
  localparam logic [1:0]  ID_NONE     = 2'h3;
  // frequency select width and default code, value arbitrary
  localparam int unsigned FSEL_W      = 3;
  localparam logic [2:0]  FSEL_DEF    = 3'h0;
  // number of request lines the agent samples at reset release
  localparam int unsigned REQ_LINES   = 2;
  // synchroniser depth for pin inputs
  localparam int unsigned SYNC_STAGES = 3;

  typedef enum logic [1:0] {
    ARB_IDLE   = 2'h0,
    ARB_REQ    = 2'h1,
    ARB_OWN    = 2'h3,
    ARB_LOCKED = 2'h2
  } arb_state_t;
endpackage
`default_nettype wire

//--- rtl/pin_sync.sv
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             mclk,  // bus clock
  input  wire logic             nrst,  // async reset, low
  input  wire logic [WIDTH-1:0] pinIn, // raw pin levels
  output logic      [WIDTH-1:0] level  // filtered level
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // three stage flops and an output flop, a change counts once stages two and three agree
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= RESET_VAL;
      stage2 <= RESET_VAL;
      stage3 <= RESET_VAL;
      level  <= RESET_VAL;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          level[i] <= stage3[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/shared_bus_priority_arbitration.sv
// Notes on behaviour
// - Seeing the priority request asserted stops the agent from issuing new requests.
// - Requests belonging to a locked operation already under way may still be issued.
// - Both request lines are sampled when reset goes from asserted to released.
// - The agent identity follows which request line was seen asserted at release.
// - Request line zero is the agent's own bus request output, driving system request zero.
// - A 3-bit frequency select code is driven; all agents share one bus frequency.
`default_nettype none
module shared_bus_priority_arbitration #(
  parameter logic [2:0] FREQ_CODE = bus_arb_pkg::FSEL_DEF
) (
  input  wire logic       mclk,                      // bus clock, 40 MHz
  input  wire logic       nrst,                      // async reset, low
  input  wire logic       priority_owner_request_n,  // priority agent request, low
  input  wire logic [1:0] agent_request_lines_n,     // request lines, input side
  input  wire logic       reqValid,                  // core wants the bus
  input  wire logic       reqLocked,                 // request is part of locked op
  input  wire logic       lockActive,                // locked op in progress
  input  wire logic       reqDone,                   // current transaction finished
  output logic            own_request_line_n,        // request line zero out, low
  output logic            own_request_oe,            // enable for request line zero
  output logic            reqGrant,                  // request issued this cycle
  output logic            reqBlocked,                // request held back this cycle
  output logic [1:0]      agentId,                   // identity caught at release
  output logic            idValid,                   // identity has been caught
  output logic [2:0]      bus_freq_select            // frequency select code
);
  // idle level of an active-low pin, also the released level of line zero
  localparam logic PIN_IDLE = 1'b1;

  // synchronised priority level, high while the priority agent is idle
  logic                    priorityActive;
  // high only until the first clocked edge after reset release
  logic                    inReset;
  // ownership sequencer state and its next value
  bus_arb_pkg::arb_state_t state;
  bus_arb_pkg::arb_state_t next_state;
  // priority agent quiet, and locked traffic allowed through
  logic                    prioQuiet;
  logic                    lockPass;
  // a new request may go out this cycle
  logic                    allowIssue;
  // a waiting request is taken, or held back, at this edge
  logic                    takeReq;
  logic                    holdReq;
  // the sequencer wants the bus after this edge
  logic                    busWanted;

  // synchronise the priority request pin, idle level out of reset
  pin_sync #(
    .WIDTH     (1),
    .RESET_VAL (PIN_IDLE)
  ) uPrioSync (
    .mclk  (mclk),
    .nrst  (nrst),
    .pinIn (priority_owner_request_n),
    .level (priorityActive)
  );

  // identity decode from the raw request lines, line zero wins a tie
  function automatic logic [1:0] decode_id(input logic [1:0] linesN);
    if (!linesN[0]) begin
      decode_id = bus_arb_pkg::ID_LINE0;
    end else if (!linesN[1]) begin
      decode_id = bus_arb_pkg::ID_LINE1;
    end else begin
      // both lines high leaves the agent without an identity
      decode_id = bus_arb_pkg::ID_NONE;
    end
  endfunction

  // true for a state that leaves the request line released
  function automatic logic is_idle(input bus_arb_pkg::arb_state_t s);
    is_idle = (s == bus_arb_pkg::ARB_IDLE);
  endfunction

  // state a taken request moves to, locked ops keep their own state
  function automatic bus_arb_pkg::arb_state_t issue_state(input logic locked);
    issue_state = locked ? bus_arb_pkg::ARB_LOCKED : bus_arb_pkg::ARB_REQ;
  endfunction

  // first clocked cycle after release marks the capture point
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      inReset <= 1'b1;
    end else begin
      inReset <= 1'b0;
    end
  end

  // identity, caught once on the first edge after release
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      agentId <= bus_arb_pkg::ID_NONE;
    end else if (inReset && !idValid) begin
      // the lines are straps held through reset, so they are read raw
      agentId <= decode_id(agent_request_lines_n);
    end
  end

  // identity caught flag, set together with the identity
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      idValid <= 1'b0;
    end else if (inReset) begin
      idValid <= 1'b1;
    end
  end

  // priority agent quiet when its synchronised pin is high
  always_comb begin
    prioQuiet = priorityActive;
    lockPass  = lockActive && reqLocked;
  end

  // new requests wait while priority is seen, locked ones still pass
  always_comb begin
    allowIssue = prioQuiet || lockPass;
  end

  // a waiting request is either taken or held back, never both
  always_comb begin
    // both need a known identity first
    takeReq = is_idle(state) && reqValid && idValid && allowIssue;
    holdReq = is_idle(state) && reqValid && idValid && !allowIssue;
  end

  // ownership sequencing
  always_comb begin
    // hold the state unless an event moves it
    next_state = state;
    unique case (state)
      bus_arb_pkg::ARB_IDLE: begin
        // only a request the priority check lets through
        if (takeReq) begin
          next_state = issue_state(reqLocked);
        end
      end

      bus_arb_pkg::ARB_REQ: begin
        // request phase is out, the bus is owned next cycle
        next_state = bus_arb_pkg::ARB_OWN;
      end

      bus_arb_pkg::ARB_OWN: begin
        // owned until the transaction completes
        if (reqDone) begin
          next_state = bus_arb_pkg::ARB_IDLE;
        end
      end

      bus_arb_pkg::ARB_LOCKED: begin
        // a locked op keeps the bus until the transaction completes with the lock dropped
        if (reqDone && !lockActive) begin
          next_state = bus_arb_pkg::ARB_IDLE;
        end
      end
    endcase
  end

  // bus wanted from the edge that takes a request until idle
  always_comb begin
    busWanted = !is_idle(next_state);
  end

  // sequencer state register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= bus_arb_pkg::ARB_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // request line zero, low while the bus is wanted
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      own_request_line_n <= PIN_IDLE;
    end else begin
      own_request_line_n <= !busWanted;
    end
  end

  // line zero driven only once the identity is known
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      own_request_oe <= 1'b0;
    end else begin
      own_request_oe <= idValid;
    end
  end

  // one-cycle pulse for each request taken
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reqGrant <= 1'b0;
    end else begin
      reqGrant <= takeReq;
    end
  end

  // held-back flag, refreshed every cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reqBlocked <= 1'b0;
    end else begin
      reqBlocked <= holdReq;
    end
  end

  // fixed frequency select, same code for every agent
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bus_freq_select <= bus_arb_pkg::FSEL_DEF;
    end else begin
      bus_freq_select <= FREQ_CODE;
    end
  end
endmodule
`default_nettype wire
